// ===== tdf_pkg.sv
package tdf_pkg;
    localparam logic [15:0] TDF_CTRL_OFS = 16'h3828;
    localparam logic [15:0] TDF_ABS_OFS = 16'h382C;
    localparam logic [15:0] TDF_STAT_OFS = 16'h3830;
    localparam logic [15:0] TDF_MASK_OFS = 16'h3834;
    localparam logic [15:0] TDF_STATE_OFS = 16'h3838;
    localparam int TDF_PF_LSB = 0;
    localparam int TDF_PF_W = 6;
    localparam int TDF_HA_LSB = 8;
    localparam int TDF_HA_W = 8;
    localparam int TDF_WB_LSB = 16;
    localparam int TDF_WB_W = 6;
    localparam int TDF_UNIT_BIT = 24;
    localparam int TDF_LW_LSB = 25;
    localparam int TDF_LW_W = 7;
    localparam logic [31:0] TDF_CTRL_WMASK = 32'hFF3F_FF3F;
    localparam logic [31:0] TDF_ABS_WMASK = 32'h0000_FFFF;
    localparam logic [31:0] TDF_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] TDF_ABS_RST = 32'h0000_0000;
    localparam int TDF_STAT_LOW_BIT = 0;
    localparam int TDF_STAT_WR_BIT = 1;
    localparam int TDF_STAT_W = 2;
    localparam logic [1:0] TDF_STAT_RST = 2'h0;
    localparam int TDF_LW_MULT = 8;
    localparam int TDF_DESC_BYTES = 16;
    localparam int TDF_TICK_NS = 1024;
    localparam int TDF_CLK_NS = 10;
endpackage

// ===== tdf_abs_timer.sv
`timescale 1ns/1ns
module tdf_abs_timer
    import tdf_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [CNT_W-1:0] delay,
    input wire logic start,
    input wire logic halt,
    output logic expire,
    output logic running
);
    localparam int ACC_W = $clog2(TDF_TICK_NS + TDF_CLK_NS) + 1;
    localparam logic [ACC_W-1:0] STEP = ACC_W'(TDF_CLK_NS);
    localparam logic [ACC_W-1:0] TICK = ACC_W'(TDF_TICK_NS);

    logic [ACC_W-1:0] acc_ff;
    logic [ACC_W-1:0] nxt_acc;
    logic tick;
    logic [CNT_W-1:0] cnt_ff;
    logic run_ff;
    logic exp_ff;

    if (CNT_W < 1) begin : gen_cnt_chk
        $error("tdf_abs_timer: CNT_W must be positive");
    end

    // Fractional tick: 1.024 us on average from a 10 ns clock
    always_comb begin
        nxt_acc = acc_ff + STEP;
        tick = (nxt_acc >= TICK);
        if (tick) begin
            nxt_acc = nxt_acc - TICK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            acc_ff <= '0;
        end else begin
            acc_ff <= nxt_acc;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            run_ff <= 1'b0;
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end else begin
            exp_ff <= 1'b0;
            if (halt) begin
                run_ff <= 1'b0;
            end else if (start && !run_ff && delay != '0) begin
                run_ff <= 1'b1;
                cnt_ff <= delay;
            end else if (run_ff && tick) begin
                if (cnt_ff == CNT_W'(1)) begin
                    run_ff <= 1'b0;
                    exp_ff <= 1'b1;
                end else begin
                    cnt_ff <= cnt_ff - CNT_W'(1);
                end
            end
        end
    end

    assign expire = exp_ff;
    assign running = run_ff;
endmodule

// ===== tdf_fetch_wrbk_ctl.sv
`timescale 1ns/1ns
module tdf_fetch_wrbk_ctl
    import tdf_pkg::*;
#(
    parameter int CACHE_LINE_BYTES = 64,
    parameter int CACHE_W = 8,
    parameter int ACC_W = 10
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic [15:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic WB_WE_I,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [CACHE_W-1:0] CACHE_COUNT,
    input wire logic [15:0] HEAD_PTR,
    input wire logic [15:0] RING_TAIL_POINTER,
    input wire logic [15:0] RING_SIZE,
    input wire logic FETCH_BUSY,
    input wire logic PRIO_PEND,
    input wire logic DESC_DONE,
    input wire logic REPORT_STATUS_FLAG,
    input wire logic DELAY_ENABLE_FLAG,
    input wire logic FLUSH,
    input wire logic IMM_INT,
    input wire logic PKT_TIMER_INT,
    output logic FETCH_REQ,
    output logic [15:0] FETCH_NUM,
    output logic WRBK_REQ,
    output logic [ACC_W-1:0] WRBK_NUM,
    output logic DESC_WRITTEN_EVENT,
    output logic INT_OUT
);
    import tdf_pkg::*;

    localparam int CL_DESC = CACHE_LINE_BYTES / TDF_DESC_BYTES;

    // Parameter checks, refused at elaboration
    if (CACHE_LINE_BYTES < TDF_DESC_BYTES) begin : gen_line_min_chk
        $error("tdf_fetch_wrbk_ctl: cache line shorter than one descriptor");
    end
    if (CACHE_LINE_BYTES % TDF_DESC_BYTES != 0) begin : gen_line_mult_chk
        $error("tdf_fetch_wrbk_ctl: cache line must be a multiple of the descriptor size");
    end
    // Scaled levels travel on 16-bit compare paths
    if (CL_DESC * ((1 << TDF_HA_W) - 1) > 32'h0000_FFFF) begin : gen_line_max_chk
        $error("tdf_fetch_wrbk_ctl: cache line too long for 16-bit levels");
    end
    if (CACHE_W < 1 || CACHE_W > 16) begin : gen_cache_chk
        $error("tdf_fetch_wrbk_ctl: CACHE_W must lie in 1..16");
    end
    if (ACC_W < 1 || ACC_W > 16) begin : gen_acc_chk
        $error("tdf_fetch_wrbk_ctl: ACC_W must lie in 1..16");
    end
    // Saturated accumulator must still exceed the largest write-back level
    if ((1 << ACC_W) - 1 <= CL_DESC * ((1 << TDF_WB_W) - 1)) begin : gen_acc_range_chk
        $error("tdf_fetch_wrbk_ctl: ACC_W too narrow for the write-back level");
    end

    logic [31:0] ctrl_ff;
    logic [31:0] abs_ff;
    logic [TDF_STAT_W-1:0] stat_ff;
    logic [TDF_STAT_W-1:0] mask_ff;
    logic ack_ff;
    logic [31:0] rdat_ff;
    logic [15:0] pend_prev_ff;
    logic [CACHE_W-1:0] cache_prev_ff;
    logic [ACC_W-1:0] acc_ff;
    logic started_ff;
    logic fetch_req_ff;
    logic [15:0] fetch_num_ff;
    logic wrbk_req_ff;
    logic [ACC_W-1:0] wrbk_num_ff;
    logic int_ff;

    logic bus_req;
    logic bus_wr;
    logic [31:0] bus_mask;
    logic unit_desc;
    logic [15:0] pf_units;
    logic [15:0] ha_units;
    logic [15:0] wb_units;
    logic [15:0] lw_thr;
    logic [15:0] pending;
    logic [15:0] cache16;
    logic [15:0] host_avail;
    logic low_event;
    logic counted;
    logic [ACC_W-1:0] acc_now;
    logic wrbk_fire;
    logic fetch_fire;
    logic abs_expire;
    logic abs_halt;
    logic [TDF_STAT_W-1:0] stat_set;
    logic [TDF_STAT_W-1:0] stat_clr;

    function automatic logic [15:0] scale_level(input logic [7:0] lvl, input logic desc_units);
        logic [15:0] wide;
        wide = {8'h00, lvl};
        if (desc_units) begin
            scale_level = wide;
        end else begin
            scale_level = 16'(wide * CL_DESC);
        end
    endfunction

    // Bus decode, one wait state
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_ff;
    assign bus_wr = bus_req && WB_WE_I;
    assign bus_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_ff <= TDF_CTRL_RST;
            abs_ff <= TDF_ABS_RST;
            mask_ff <= TDF_STAT_RST;
        end else if (bus_wr) begin
            unique case (WB_ADR_I)
                TDF_CTRL_OFS: begin
                    ctrl_ff <= (ctrl_ff & ~(bus_mask & TDF_CTRL_WMASK)) | (WB_DAT_I & bus_mask & TDF_CTRL_WMASK);
                end
                TDF_ABS_OFS: begin
                    abs_ff <= (abs_ff & ~(bus_mask & TDF_ABS_WMASK)) | (WB_DAT_I & bus_mask & TDF_ABS_WMASK);
                end
                TDF_MASK_OFS: begin
                    if (WB_SEL_I[0]) begin
                        mask_ff <= WB_DAT_I[TDF_STAT_W-1:0];
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdat_ff <= 32'h0000_0000;
        end else if (bus_req && !WB_WE_I) begin
            unique case (WB_ADR_I)
                TDF_CTRL_OFS: rdat_ff <= ctrl_ff & TDF_CTRL_WMASK;
                TDF_ABS_OFS: rdat_ff <= abs_ff & TDF_ABS_WMASK;
                TDF_STAT_OFS: rdat_ff <= {{(32-TDF_STAT_W){1'b0}}, stat_ff};
                TDF_MASK_OFS: rdat_ff <= {{(32-TDF_STAT_W){1'b0}}, mask_ff};
                TDF_STATE_OFS: rdat_ff <= {pending, 16'(acc_ff)};
                default: rdat_ff <= 32'h0000_0000;
            endcase
        end
    end

    // Threshold decode
    assign unit_desc = ctrl_ff[TDF_UNIT_BIT];
    assign pf_units = scale_level(8'(ctrl_ff[TDF_PF_LSB +: TDF_PF_W]), unit_desc);
    assign ha_units = scale_level(ctrl_ff[TDF_HA_LSB +: TDF_HA_W], unit_desc);
    assign wb_units = scale_level(8'(ctrl_ff[TDF_WB_LSB +: TDF_WB_W]), unit_desc);
    assign lw_thr = 16'({9'h000, ctrl_ff[TDF_LW_LSB +: TDF_LW_W]} * TDF_LW_MULT);

    // Ring occupancy from in-progress head to tail
    always_comb begin
        if (RING_TAIL_POINTER >= HEAD_PTR) begin
            pending = RING_TAIL_POINTER - HEAD_PTR;
        end else begin
            pending = 16'(RING_TAIL_POINTER + RING_SIZE - HEAD_PTR);
        end
    end

    assign cache16 = 16'(CACHE_COUNT);
    // Host-side count excludes what the cache already holds
    always_comb begin
        if (pending > cache16) begin
            host_avail = pending - cache16;
        end else begin
            host_avail = 16'h0000;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pend_prev_ff <= 16'h0000;
            cache_prev_ff <= '0;
        end else begin
            pend_prev_ff <= pending;
            cache_prev_ff <= CACHE_COUNT;
        end
    end

    always_comb begin
        if (lw_thr != 16'h0000) begin
            low_event = (pend_prev_ff == 16'(lw_thr + 16'h0001)) && (pending == lw_thr);
        end else begin
            low_event = (cache_prev_ff != '0) && (CACHE_COUNT == '0);
        end
    end

    // Write-back accumulation
    assign counted = DESC_DONE && (started_ff || REPORT_STATUS_FLAG);
    assign acc_now = acc_ff + ACC_W'(counted);
    assign wrbk_fire = (acc_now != '0) && (FLUSH || (16'(acc_now) > wb_units));

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            wrbk_req_ff <= 1'b0;
            wrbk_num_ff <= '0;
        end else begin
            wrbk_req_ff <= wrbk_fire;
            if (wrbk_fire) begin
                wrbk_num_ff <= acc_now;
            end
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            acc_ff <= '0;
            started_ff <= 1'b0;
        end else begin
            if (wrbk_fire) begin
                acc_ff <= '0;
                started_ff <= 1'b0;
            end else begin
                if (acc_now != '1) begin
                    acc_ff <= acc_now;
                end
                if (DESC_DONE && REPORT_STATUS_FLAG) begin
                    started_ff <= 1'b1;
                end
            end
        end
    end

    // Prefetch pacing
    assign fetch_fire = (cache16 < pf_units)
        && (host_avail >= ha_units) && (host_avail != 16'h0000)
        && !PRIO_PEND && !FETCH_BUSY && !fetch_req_ff && !wrbk_fire && !wrbk_req_ff;

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fetch_req_ff <= 1'b0;
            fetch_num_ff <= 16'h0000;
        end else begin
            fetch_req_ff <= fetch_fire;
            if (fetch_fire) begin
                fetch_num_ff <= host_avail;
            end
        end
    end

    // Clearing the delay register stops a running countdown
    assign abs_halt = IMM_INT || PKT_TIMER_INT || abs_ff[15:0] == 16'h0000;

    tdf_abs_timer #(
        .CNT_W(16)
    ) u_abs_timer (
        .clk(SYS_CLK),
        .rstn(RSTN),
        .delay(abs_ff[15:0]),
        .start(DESC_DONE && REPORT_STATUS_FLAG && DELAY_ENABLE_FLAG),
        .halt(abs_halt),
        .expire(abs_expire),
        .running()
    );

    // Sticky status, set beats write-one-to-clear
    always_comb begin
        stat_set = '0;
        stat_set[TDF_STAT_LOW_BIT] = low_event;
        stat_set[TDF_STAT_WR_BIT] = abs_expire;
        stat_clr = '0;
        if (bus_wr && WB_ADR_I == TDF_STAT_OFS && WB_SEL_I[0]) begin
            stat_clr = WB_DAT_I[TDF_STAT_W-1:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            stat_ff <= TDF_STAT_RST;
        end else begin
            stat_ff <= (stat_ff & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
            int_ff <= 1'b0;
        end else begin
            int_ff <= |(((stat_ff & ~stat_clr) | stat_set) & mask_ff);
        end
    end

    assign WB_ACK_O = ack_ff;
    assign WB_DAT_O = rdat_ff;
    assign FETCH_REQ = fetch_req_ff;
    assign FETCH_NUM = fetch_num_ff;
    assign WRBK_REQ = wrbk_req_ff;
    assign WRBK_NUM = wrbk_num_ff;
    assign DESC_WRITTEN_EVENT = abs_expire;
    assign INT_OUT = int_ff;
endmodule

// ===== tdf_chk.sv
`timescale 1ns/1ns
module tdf_chk #(
    parameter int ACC_W = 10
) (
    input wire logic SYS_CLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_ACK_O,
    input wire logic FETCH_BUSY,
    input wire logic PRIO_PEND,
    input wire logic FETCH_REQ,
    input wire logic [15:0] FETCH_NUM,
    input wire logic DESC_DONE,
    input wire logic FLUSH,
    input wire logic WRBK_REQ,
    input wire logic [ACC_W-1:0] WRBK_NUM,
    input wire logic DESC_WRITTEN_EVENT
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RSTN);
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("bus request not answered");
    ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held too long");
    fetch_space_a: assert property (FETCH_REQ |=> !FETCH_REQ)
        else $error("fetch requests too close");
    fetch_defer_a: assert property (PRIO_PEND || FETCH_BUSY |=> !FETCH_REQ)
        else $error("fetch while dma pending");
    fetch_host_a: assert property (FETCH_REQ |-> FETCH_NUM != 16'h0)
        else $error("fetch with nothing in host");
    wrbk_cause_a: assert property (WRBK_REQ |-> $past(DESC_DONE) || $past(FLUSH))
        else $error("write-back without cause");
    wrbk_count_a: assert property (WRBK_REQ |-> WRBK_NUM != '0)
        else $error("empty write-back");
    expiry_pulse_a: assert property (DESC_WRITTEN_EVENT |=> !DESC_WRITTEN_EVENT)
        else $error("expiry pulse held");
endmodule
bind tdf_fetch_wrbk_ctl tdf_chk #(.ACC_W(ACC_W)) tdf_chk_i (.SYS_CLK, .RSTN, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .FETCH_BUSY, .PRIO_PEND, .FETCH_REQ, .FETCH_NUM, .DESC_DONE, .FLUSH, .WRBK_REQ,
    .WRBK_NUM, .DESC_WRITTEN_EVENT);

// ===== tdf_host_mdl.sv
`timescale 1ns/1ns
module tdf_host_mdl (
    input wire logic clk,
    input wire logic rstn,
    input wire logic fetch_req,
    input wire logic wrbk_req,
    input wire logic slow,
    input wire logic hold,
    output logic fetch_busy,
    output logic prio_pend
);
    logic [3:0] f_cnt_ff;
    logic [3:0] w_cnt_ff;
    // Host memory busy for 3 or 9 cycles per transfer
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            f_cnt_ff <= 4'h0;
            w_cnt_ff <= 4'h0;
        end else begin
            if (fetch_req) f_cnt_ff <= slow ? 4'h9 : 4'h3;
            else if (f_cnt_ff != 4'h0) f_cnt_ff <= f_cnt_ff - 4'h1;
            if (wrbk_req) w_cnt_ff <= slow ? 4'h9 : 4'h3;
            else if (w_cnt_ff != 4'h0) w_cnt_ff <= w_cnt_ff - 4'h1;
        end
    end
    assign fetch_busy = f_cnt_ff != 4'h0;
    assign prio_pend = hold || w_cnt_ff != 4'h0;
endmodule

// ===== test_tx_descriptor_fetch_writeback_ctl.sv
`timescale 1ns/1ns
module test_tx_descriptor_fetch_writeback_ctl;
    import tdf_pkg::*;
    logic clk = 1'b0, rstn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
    logic done = 1'b0, rs = 1'b0, delay_enable_flag = 1'b0, flush = 1'b0, imm = 1'b0, pkt = 1'b0;
    logic slow = 1'b0, hold = 1'b0, fbusy, prio, freq, wreq, dwe, irq, started = 1'b0;
    logic [15:0] adr = '0, head = '0, tail = 16'h28, fnum, seed = 16'hF4AF;
    logic [31:0] dat = '0, rdat;
    logic [31:0] rd_q[$], wb_q[$], f_q[$];
    logic [7:0] cache = 8'h14;
    logic [9:0] wnum;
    logic [15:0] regs[5] = '{TDF_CTRL_OFS, TDF_ABS_OFS, TDF_STAT_OFS, TDF_MASK_OFS, 16'h3900};
    int num_errors = 0, compares = 0, ev = 0, acc = 0, wbu = 0, n;
    always #5 clk = ~clk;
    tdf_fetch_wrbk_ctl tdf_fetch_wrbk_ctl_i (.SYS_CLK(clk), .RSTN(rstn), .WB_ADR_I(adr), .WB_DAT_I(dat),
        .WB_SEL_I(4'hF), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack),
        .CACHE_COUNT(cache), .HEAD_PTR(head), .RING_TAIL_POINTER(tail), .RING_SIZE(16'h40),
        .FETCH_BUSY(fbusy), .PRIO_PEND(prio), .DESC_DONE(done), .REPORT_STATUS_FLAG(rs),
        .DELAY_ENABLE_FLAG(delay_enable_flag), .FLUSH(flush), .IMM_INT(imm), .PKT_TIMER_INT(pkt), .FETCH_REQ(freq),
        .FETCH_NUM(fnum), .WRBK_REQ(wreq), .WRBK_NUM(wnum), .DESC_WRITTEN_EVENT(dwe), .INT_OUT(irq));
    tdf_host_mdl tdf_host_mdl_i (.clk(clk), .rstn(rstn), .fetch_req(freq), .wrbk_req(wreq), .slow(slow),
        .hold(hold), .fetch_busy(fbusy), .prio_pend(prio));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic [31:0] e, input logic [31:0] a);
        compares++;
        if (a !== e) begin
            num_errors++;
            $display("ERROR t=%0t exp=%h act=%h", $time, e, a);
        end
    endtask
    task automatic take(ref logic [31:0] q[$], input logic [31:0] a);
        if (q.size() == 0) begin
            num_errors++;
            $display("ERROR t=%0t exp=none act=%h", $time, a);
        end else begin
            chk(q.pop_front(), a);
        end
    endtask
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0) take(rd_q, rdat);
        if (wreq === 1'b1) take(wb_q, 32'(wnum));
        if (freq === 1'b1) take(f_q, 32'(fnum));
        if (dwe === 1'b1) ev++;
    end
    task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        adr <= a;
        we <= w;
        dat <= d;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (ack !== 1'b1) num_errors++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
        if (a == TDF_CTRL_OFS) wbu = d[24] ? d[21:16] : d[21:16] * 64 / TDF_DESC_BYTES;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        bus(a, 1'b0, '0);
    endtask
    // Pulse one descriptor and predict its write-back
    task automatic desc(input logic r, input logic i);
        done <= 1'b1;
        rs <= r;
        delay_enable_flag <= i;
        if (r || started) begin
            started = 1'b1;
            acc++;
        end
        if (acc > wbu) begin
            wb_q.push_back(acc);
            acc = 0;
            started = 1'b0;
        end
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
    endtask
    task automatic wrap_up();
        if (num_errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        foreach (regs[k]) rd(regs[k], '0);
        rd(TDF_STATE_OFS, 32'h0028_0000);
        wr(TDF_CTRL_OFS, TDF_CTRL_WMASK);
        rd(TDF_CTRL_OFS, TDF_CTRL_WMASK);
        wr(TDF_ABS_OFS, TDF_ABS_WMASK);
        rd(TDF_ABS_OFS, 32'h0000_FFFF);
        wr(TDF_CTRL_OFS, 32'h0100_0000);
        desc(1'b0, 1'b0);
        desc(1'b1, 1'b0);
        for (int g = 0; g < 2; g++) begin
            seed = lfsr(seed);
            wr(TDF_CTRL_OFS, {7'h0, g[0], 2'h0, 4'h0, seed[1:0], 16'h0});
            repeat (30) begin
                seed = lfsr(seed);
                desc(seed[0] & seed[1], 1'b0);
            end
            flush <= 1'b1;
            if (acc > 0) wb_q.push_back(acc);
            acc = 0;
            started = 1'b0;
            @(posedge clk);
            flush <= 1'b0;
            repeat (2) @(posedge clk);
        end
        slow <= seed[2];
        hold <= 1'b1;
        cache <= 8'h04;
        wr(TDF_CTRL_OFS, 32'h0100_2808);
        repeat (10) @(posedge clk);
        wr(TDF_CTRL_OFS, 32'h0100_2408);
        repeat (10) @(posedge clk);
        f_q.push_back(32'h24);
        hold <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (freq !== 1'b1 && n < 50);
        cache <= 8'h14;
        wr(TDF_CTRL_OFS, 32'h0200_0000);
        chk(32'h0, 32'(f_q.size()));
        head <= 16'h1F;
        repeat (3) @(posedge clk);
        head <= 16'h20;
        repeat (3) @(posedge clk);
        chk(32'h0, 32'(irq));
        rd(TDF_STAT_OFS, 32'h1);
        wr(TDF_MASK_OFS, 32'h3);
        chk(32'h1, 32'(irq));
        wr(TDF_STAT_OFS, 32'h1);
        @(posedge clk);
        chk(32'h0, 32'(irq));
        wr(TDF_CTRL_OFS, '0);
        cache <= 8'h00;
        repeat (3) @(posedge clk);
        rd(TDF_STAT_OFS, 32'h1);
        wr(TDF_STAT_OFS, 32'h1);
        wr(TDF_ABS_OFS, 32'h2);
        desc(1'b1, 1'b1);
        repeat (100) @(posedge clk);
        chk(32'h0, ev);
        repeat (220) @(posedge clk);
        chk(32'h1, ev);
        rd(TDF_STAT_OFS, 32'h2);
        for (int k = 0; k < 2; k++) begin
            desc(1'b1, 1'b1);
            imm <= ~k[0];
            pkt <= k[0];
            @(posedge clk);
            imm <= 1'b0;
            pkt <= 1'b0;
            repeat (330) @(posedge clk);
            chk(32'h1, ev);
        end
        wr(TDF_ABS_OFS, '0);
        desc(1'b1, 1'b1);
        repeat (330) @(posedge clk);
        chk(32'h1, ev);
        head <= 16'h30;
        @(posedge clk);
        rd(TDF_STATE_OFS, 32'h0038_0000);
        repeat (5) @(posedge clk);
        chk(32'h0, 32'(wb_q.size() + f_q.size() + rd_q.size()));
        wrap_up();
    end
endmodule
